// file: rtl/eew_device.sv
// eew_device: eeprom array with control register, row latches and busy timer
// assumes the cpu side gives single-cycle strobes on eew_if
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module eew_device
  import eew_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // cpu side bus
  eew_if.device bus,
  // status to the system
  output logic nvmPowerDown,
  output logic writeInProgress
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef enum logic [1:0] {IDLE, PROG_BYTE, PROG_ROW} eew_state_e;

  eew_state_e state_q;
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic powerDown_q;
  logic writeEnable_q;
  logic rowLoad_q;
  logic rowStart_q;
  logic [TMR_W-1:0] timer_q;
  logic [DATA_W-1:0] rowLatch_q [ROW_BYTES];
  logic [ROW_BYTES-1:0] rowValid_q;
  logic rowLocked_q;
  logic [2:0] rowAddr_q;
  logic [ADDR_W-1:0] byteAddr_q;
  logic [DATA_W-1:0] byteData_q;

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  wire busy = (state_q != IDLE);
  wire accessBlocked = busy | powerDown_q;
  wire [2:0] reqRow = bus.eeAddr[ADDR_W-1:3];
  wire [2:0] reqCol = bus.eeAddr[2:0];
  wire ctlAccept = bus.ctlWrite & ~busy;
  wire wrLoadBit = bus.eeWData[CTL_ROW_LOAD];
  wire wrStartBit = bus.eeWData[CTL_ROW_START];
  wire wrEnableBit = bus.eeWData[CTL_WRITE_EN];
  wire startOk = ctlAccept & wrStartBit & wrEnableBit & wrLoadBit & rowLoad_q;
  wire loadRise = ctlAccept & wrLoadBit & ~rowLoad_q;
  // early load clear drops the row
  wire loadDrop = ctlAccept & ~wrLoadBit;
  wire eeWrOk = bus.eeWrite & ~accessBlocked;
  // row locked on first load write
  wire rowMatch = ~rowLocked_q | (rowAddr_q == reqRow);
  wire latchWrite = eeWrOk & rowLoad_q & rowMatch;
  wire byteStart = eeWrOk & ~rowLoad_q & writeEnable_q;
  wire progDone = busy & (timer_q == '0);

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  // same-cycle read, gated off
  assign bus.eeRData = accessBlocked ? 8'h00 : mem_q[bus.eeAddr];
  // only the busy flag reads back
  assign bus.ctlRData = {6'h00, busy, 1'b0};
  assign bus.refused = ((bus.eeWrite | bus.eeRead) & accessBlocked) | (bus.ctlWrite & busy);
  // power down out to the array supply
  assign nvmPowerDown = powerDown_q;
  assign writeInProgress = busy;

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= IDLE;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (startOk) begin
            state_q <= PROG_ROW;
          end else if (byteStart) begin
            state_q <= PROG_BYTE;
          end
        end
        PROG_BYTE, PROG_ROW: begin
          if (progDone) begin
            state_q <= IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_q <= '0;
    end else if (startOk | byteStart) begin
      timer_q <= TMR_W'(PROG_CYCLES - 1);
    end else if (busy & ~progDone) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // ----------------------------------------------------------
  // control register
  // ----------------------------------------------------------
  // reset to zero, frozen while busy
  always_ff @(posedge clk) begin
    if (reset) begin
      powerDown_q <= CTL_RESET[CTL_POWER_DOWN];
      writeEnable_q <= CTL_RESET[CTL_WRITE_EN];
    end else if (ctlAccept) begin
      powerDown_q <= bus.eeWData[CTL_POWER_DOWN];
      writeEnable_q <= wrEnableBit;
    end
  end

  // load and start clear at row end
  always_ff @(posedge clk) begin
    if (reset) begin
      rowLoad_q <= CTL_RESET[CTL_ROW_LOAD];
      rowStart_q <= CTL_RESET[CTL_ROW_START];
    end else if (progDone & (state_q == PROG_ROW)) begin
      rowLoad_q <= 1'b0;
      rowStart_q <= 1'b0;
    end else if (ctlAccept) begin
      rowLoad_q <= wrLoadBit;
      rowStart_q <= startOk;
    end
  end

  // ----------------------------------------------------------
  // row latches
  // ----------------------------------------------------------
  // row address held until end or drop
  always_ff @(posedge clk) begin
    if (reset) begin
      rowLocked_q <= 1'b0;
      rowAddr_q <= '0;
    end else if (loadRise | loadDrop | progDone) begin
      rowLocked_q <= 1'b0;
    end else if (latchWrite & ~rowLocked_q) begin
      rowLocked_q <= 1'b1;
      rowAddr_q <= reqRow;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rowValid_q <= '0;
      for (int i = 0; i < ROW_BYTES; i++) begin
        rowLatch_q[i] <= '0;
      end
    end else if (loadRise) begin
      rowValid_q <= '0;
      for (int i = 0; i < ROW_BYTES; i++) begin
        rowLatch_q[i] <= '0;
      end
    end else if (loadDrop | progDone) begin
      rowValid_q <= '0;
    end else if (latchWrite) begin
      rowValid_q[reqCol] <= 1'b1;
      rowLatch_q[reqCol] <= bus.eeWData;
    end
  end

  // byte mode target held during programming
  always_ff @(posedge clk) begin
    if (reset) begin
      byteAddr_q <= '0;
      byteData_q <= '0;
    end else if (byteStart) begin
      byteAddr_q <= bus.eeAddr;
      byteData_q <= bus.eeWData;
    end
  end

  // ----------------------------------------------------------
  // array
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (progDone & (state_q == PROG_BYTE)) begin
      // byte lands at its own address
      mem_q[byteAddr_q] <= byteData_q;
    end else if (progDone & rowStart_q) begin
      for (int i = 0; i < ROW_BYTES; i++) begin
        if (rowValid_q[i]) begin
          mem_q[{rowAddr_q, 3'(i)}] <= rowLatch_q[i];
        end
      end
    end
  end

endmodule : eew_device
`default_nettype wire

// file: rtl/eew_host.sv
// eew_host: apb slave that turns software accesses into eeprom bus strobes
// assumes apb master on the same clock; every access completes in one cycle
`timescale 1ns/10ps
`default_nettype none
module eew_host
  import eew_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // eeprom side bus
  eew_if.host bus
);

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic refused_q;

  wire access = psel & penable;
  wire selAddr = (paddr == OFS_ADDR);
  wire selData = (paddr == OFS_DATA);
  wire selCtl = (paddr == OFS_CTL);
  wire selStat = (paddr == OFS_STAT);
  wire mapped = selAddr | selData | selCtl | selStat;
  // data accesses use the address held in addr_q
  assign bus.eeAddr = addr_q;
  wire [DATA_W-1:0] testMask = DATA_W'((1 << CTL_TEST_HI) | (1 << CTL_TEST_LO));
  assign bus.eeWData = selCtl ? (pwdata[DATA_W-1:0] & ~testMask) : pwdata[DATA_W-1:0];
  assign bus.eeWrite = access & pwrite & selData;
  assign bus.eeRead = access & ~pwrite & selData;
  assign bus.ctlWrite = access & pwrite & selCtl;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  wire [31:0] statWord = {30'h0, bus.ctlRData[CTL_BUSY], refused_q};
  assign prdata = selAddr ? {26'h0, addr_q} :
                  selData ? {24'h0, bus.eeRData} :
                  selCtl ? {24'h0, bus.ctlRData} :
                  selStat ? statWord : 32'h0;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_q <= '0;
    end else if (access & pwrite & selAddr) begin
      addr_q <= pwdata[ADDR_W-1:0];
    end
  end

  // sticky refused flag, set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      refused_q <= 1'b0;
    end else if (bus.refused) begin
      refused_q <= 1'b1;
    end else if (access & pwrite & selStat & pwdata[STAT_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

endmodule : eew_host
`default_nettype wire

// file: rtl/eew_if.sv
// eew_if: internal data bus between the cpu side and the eeprom block
// assumes both ends run on the same clock; strobes are one cycle wide
`timescale 1ns/10ps
`default_nettype none
interface eew_if;
  import eew_pkg::*;
  logic [ADDR_W-1:0] eeAddr;
  logic [DATA_W-1:0] eeWData;
  logic eeWrite;
  logic eeRead;
  logic ctlWrite;
  logic [DATA_W-1:0] eeRData;
  logic [DATA_W-1:0] ctlRData;
  logic refused;

  modport device (
    input eeAddr, eeWData, eeWrite, eeRead, ctlWrite,
    output eeRData, ctlRData, refused
  );
  modport host (
    output eeAddr, eeWData, eeWrite, eeRead, ctlWrite,
    input eeRData, ctlRData, refused
  );
endinterface : eew_if
`default_nettype wire

// file: rtl/eew_pkg.sv
// eew_pkg: constants shared by the eeprom write controller ends
// assumes one 100 MHz core clock and a 64 byte eeprom array of 8 byte rows
package eew_pkg;

  // ----------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DEPTH = 64;
  localparam int ROW_BYTES = 8;

  // ----------------------------------------------------------
  // control/status register bit positions
  // ----------------------------------------------------------
  localparam int CTL_POWER_DOWN = 6;
  localparam int CTL_TEST_HI = 5;
  localparam int CTL_TEST_LO = 4;
  localparam int CTL_ROW_START = 3;
  localparam int CTL_ROW_LOAD = 2;
  localparam int CTL_BUSY = 1;
  localparam int CTL_WRITE_EN = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------------------------
  // programming time
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 5000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 13;

  // ----------------------------------------------------------
  // host apb register map
  // ----------------------------------------------------------
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam int STAT_REFUSED = 0;
  localparam int STAT_BUSY = 1;

endpackage : eew_pkg

// file: test/eew_assertions.sv
// eew_assertions: checks on the eew_if bus between host and device
// assumes one clock, sync active high reset, busy at ctlRData bit 1
`timescale 1ns/10ps
`default_nettype none
module eew_assertions
  import eew_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus signals
  input wire logic [ADDR_W-1:0] eeAddr,
  input wire logic [DATA_W-1:0] eeWData,
  input wire logic eeWrite,
  input wire logic eeRead,
  input wire logic ctlWrite,
  input wire logic [DATA_W-1:0] eeRData,
  input wire logic [DATA_W-1:0] ctlRData,
  input wire logic refused
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------
  // busy length counter
  // ----------------------------------------------------------
  wire busy = ctlRData[CTL_BUSY];
  logic [TMR_W-1:0] busyCnt_q;
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      busyCnt_q <= '0;
    end else begin
      busyCnt_q <= busyCnt_q + 1'b1;
    end
  end

  sequence s_busy_rise;
    !busy ##1 busy;
  endsequence
  sequence s_busy_fall;
    busy ##1 !busy;
  endsequence

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  chk_busy_cause: assert property (s_busy_rise |-> $past(eeWrite) || $past(ctlWrite))
    else $error("busy rose without a write");
  chk_busy_span: assert property (s_busy_fall |-> busyCnt_q == TMR_W'(PROG_CYCLES))
    else $error("busy length wrong");
  chk_busy_bound: assert property (busyCnt_q <= TMR_W'(PROG_CYCLES))
    else $error("busy held too long");
  chk_write_busy_refused: assert property (eeWrite && busy |-> refused)
    else $error("array write while busy not refused");
  chk_ctl_busy_refused: assert property (ctlWrite && busy |-> refused)
    else $error("control write while busy not refused");
  chk_ctl_idle_taken: assert property (ctlWrite && !busy |-> !refused)
    else $error("control write refused while idle");
  chk_read_busy_zero: assert property (busy |-> eeRData == 8'h00)
    else $error("array data shown while busy");
  chk_ctl_read_form: assert property (ctlRData[7:2] == 6'h00 && !ctlRData[0])
    else $error("control readback shows more than busy");
  chk_refuse_cause: assert property (refused |-> eeWrite || eeRead || ctlWrite)
    else $error("refused without an access");
  chk_test_bits_zero: assert property (ctlWrite |-> eeWData[CTL_TEST_HI:CTL_TEST_LO] == 2'h0)
    else $error("control write carries test bits");
endmodule : eew_assertions
`default_nettype wire

// file: test/eew_tb_top.sv
// eew_tb_top: apb driven test of host and device joined by eew_if
// assumes 100 MHz clock and a zero wait state apb slave
`timescale 1ns/10ps
`default_nettype none
module eew_tb_top;
  import eew_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic powerDown;
  logic wip;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int nTests = 0;
  logic [7:0] rowExp [8] = '{8'h10, 8'h00, 8'h11, 8'h12, 8'h66, 8'h00, 8'h00, 8'h00};
  logic [7:0] rowAdr [4] = '{8'h18, 8'h1A, 8'h1B, 8'h20};

  eew_if bus ();
  eew_host u_eew_host (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  eew_device u_eew_device (.clk(clk), .reset(reset), .bus(bus), .nvmPowerDown(powerDown),
    .writeInProgress(wip));
  eew_assertions u_eew_assertions (.clk(clk), .reset(reset), .eeAddr(bus.eeAddr),
    .eeWData(bus.eeWData), .eeWrite(bus.eeWrite), .eeRead(bus.eeRead), .ctlWrite(bus.ctlWrite),
    .eeRData(bus.eeRData), .ctlRData(bus.ctlRData), .refused(bus.refused));

  always #5 clk = ~clk;

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic endOfTest();
    if (mismatches == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : endOfTest

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdChk

  task automatic waitIdle();
    int i;
    i = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      i++;
    end while (rd[STAT_BUSY] !== 1'b0 && i < 1000);
    check("busy end", {31'h0, rd[STAT_BUSY]}, 32'h0);
  endtask : waitIdle

  // ----------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------
  initial begin
    #200000;
    mismatches++;
    endOfTest();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdChk("ctl reset", OFS_CTL, 32'h0);
    rdChk("stat reset", OFS_STAT, 32'h0);
    wr(OFS_ADDR, 8'h05);
    wr(OFS_DATA, 8'hAA);
    rdChk("busy when disabled", OFS_STAT, 32'h0);
    rdChk("byte when disabled", OFS_DATA, 32'h0);
    wr(OFS_CTL, 8'h01);
    wr(OFS_DATA, 8'h5A);
    @(negedge clk);
    check("busy pin", {31'h0, wip}, 32'h1);
    rdChk("busy flag", OFS_STAT, 32'h2);
    rdChk("read while busy", OFS_DATA, 32'h0);
    wr(OFS_CTL, 8'h00);
    rdChk("refused flag", OFS_STAT, 32'h3);
    waitIdle();
    wr(OFS_STAT, 8'h01);
    rdChk("byte written", OFS_DATA, 32'h5A);
    wr(OFS_ADDR, 8'h1C);
    wr(OFS_DATA, 8'h66);
    waitIdle();
    rdChk("enable kept", OFS_DATA, 32'h66);
    wr(OFS_CTL, 8'h05);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_ADDR, rowAdr[k]);
      wr(OFS_DATA, 8'h10 + k[7:0]);
    end
    wr(OFS_CTL, 8'h0D);
    rdChk("row busy", OFS_STAT, 32'h2);
    waitIdle();
    for (int k = 0; k < 8; k++) begin
      wr(OFS_ADDR, 8'h18 + k[7:0]);
      rdChk("row byte", OFS_DATA, {24'h0, rowExp[k]});
    end
    wr(OFS_ADDR, 8'h20);
    rdChk("other row", OFS_DATA, 32'h0);
    wr(OFS_ADDR, 8'h1F);
    wr(OFS_DATA, 8'h09);
    waitIdle();
    rdChk("load self cleared", OFS_DATA, 32'h9);
    wr(OFS_CTL, 8'h05);
    wr(OFS_ADDR, 8'h19);
    wr(OFS_DATA, 8'h77);
    wr(OFS_CTL, 8'h01);
    wr(OFS_CTL, 8'h09);
    rdChk("start without load", OFS_STAT, 32'h0);
    rdChk("early clear", OFS_DATA, 32'h0);
    wr(OFS_CTL, 8'h40);
    @(negedge clk);
    check("power down pin", {31'h0, powerDown}, 32'h1);
    wr(OFS_ADDR, 8'h1F);
    rdChk("read powered down", OFS_DATA, 32'h0);
    rdChk("powered refused", OFS_STAT, 32'h1);
    wr(OFS_CTL, 8'h31);
    wr(OFS_STAT, 8'h01);
    rdChk("refused cleared", OFS_STAT, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    endOfTest();
  end
endmodule : eew_tb_top
`default_nettype wire
